// ### ddr_tester_pkg.sv
package ddr_tester_pkg;
	localparam int unsigned AXI_AW         = 32;
	localparam int unsigned AXI_DW         = 64;
	localparam int unsigned CNT_W          = 32;
	localparam int unsigned BURST_CNT_W    = 6;
	localparam int unsigned BEAT_W         = 4;
	localparam int unsigned RAM_DEPTH      = 512;
	localparam int unsigned RAM_AW         = 9;
	localparam int unsigned SIZE_W         = 3;
	localparam int unsigned CMD_W          = 8;
	// Command byte layout on the processor-driven outputs
	localparam int unsigned CMD_WR_BIT     = 0;
	localparam int unsigned CMD_RD_BIT     = 1;
	localparam int unsigned CMD_WSIZE_LSB  = 2;
	localparam int unsigned CMD_RSIZE_LSB  = 5;
	// Size code n selects 2**n bursts, n capped at 5; code 4 is 2 KB
	localparam logic [2:0]  SIZE_CODE_MAX  = 3'h5;
	localparam logic [31:0] WR_BASE        = 32'h0000_0000;
	localparam logic [31:0] RD_BASE        = 32'h0010_0000;
	localparam logic [31:0] BURST_BYTES    = 32'h0000_0080;
	localparam logic [31:0] SRAM_BASE      = 32'h2000_8104;
	localparam logic [31:0] SRAM_STEP      = 32'h0000_0004;
	localparam logic [2:0]  REPEAT_LAST    = 3'h7;
	localparam logic [5:0]  MAX_RD_QUEUE   = 6'h05;
	localparam logic [3:0]  BEAT_LAST      = 4'hF;
	localparam logic [3:0]  AXI_LEN_16     = 4'hF;
	localparam logic [2:0]  AXI_SIZE_8B    = 3'h3;
	localparam logic [1:0]  AXI_BURST_INCR = 2'h1;
	localparam logic [7:0]  AXI_STRB_ALL   = 8'hFF;
	localparam logic [1:0]  AXI_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [2:0]  HSIZE_WORD     = 3'h2;
	localparam logic [2:0]  HBURST_SINGLE  = 3'h0;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_WRITE  = 3'h1,
		ST_READ   = 3'h2,
		ST_REPORT = 3'h3,
		ST_WAIT   = 3'h4
	} ctrl_state_t;

	typedef enum logic [1:0] {
		AHB_IDLE = 2'h0,
		AHB_ADDR = 2'h1,
		AHB_DATA = 2'h2
	} ahb_state_t;
endpackage

// ### ddr_axi_throughput_tester.sv
`timescale 1ns/1ps
module ddr_axi_throughput_tester (
	input  wire logic        mclk,          // Fabric and AXI clock
	input  wire logic        nrst,          // Async reset, active low
	input  wire logic        clk_en,        // Freezes all state when low
	input  wire logic [7:0]  gpio_cmd,      // Processor command outputs
	input  wire logic        ddr_ready,     // Controller configuration done
	output logic             busy,          // Test in progress
	output logic             resp_err,      // Sticky non-OKAY write or read response
	output logic [31:0]      awaddr,        // AXI write address
	output logic [3:0]       awlen,         // AXI write burst length
	output logic [2:0]       awsize,        // AXI write beat size
	output logic [1:0]       awburst,       // AXI write burst type
	output logic             awvalid,       // AXI write address valid
	input  wire logic        awready,       // AXI write address ready
	output logic [63:0]      wdata,         // AXI write data
	output logic [7:0]       wstrb,         // AXI write strobes
	output logic             wlast,         // AXI last write beat
	output logic             wvalid,        // AXI write data valid
	input  wire logic        wready,        // AXI write data ready
	input  wire logic [1:0]  bresp,         // AXI write response
	input  wire logic        bvalid,        // AXI write response valid
	output logic             bready,        // AXI write response ready
	output logic [31:0]      araddr,        // AXI read address
	output logic [3:0]       arlen,         // AXI read burst length
	output logic [2:0]       arsize,        // AXI read beat size
	output logic [1:0]       arburst,       // AXI read burst type
	output logic             arvalid,       // AXI read address valid
	input  wire logic        arready,       // AXI read address ready
	input  wire logic [63:0] rdata,         // AXI read data
	input  wire logic [1:0]  rresp,         // AXI read response
	input  wire logic        rlast,         // AXI last read beat
	input  wire logic        rvalid,        // AXI read data valid
	output logic             rready,        // AXI read data ready
	output logic [31:0]      haddr,         // AHB address
	output logic [1:0]       htrans,        // AHB transfer type
	output logic             hwrite,        // AHB write
	output logic [2:0]       hsize,         // AHB size
	output logic [2:0]       hburst,        // AHB burst
	output logic [31:0]      hwdata,        // AHB write data
	input  wire logic        hready         // AHB ready
);

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			rst_sync_reg <= 2'h0;
		else if (clk_en)
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Fixed burst shape; static fields need no flip-flop
	assign awlen   = ddr_tester_pkg::AXI_LEN_16;
	assign awsize  = ddr_tester_pkg::AXI_SIZE_8B;
	assign awburst = ddr_tester_pkg::AXI_BURST_INCR;
	assign wstrb   = ddr_tester_pkg::AXI_STRB_ALL;
	assign arlen   = ddr_tester_pkg::AXI_LEN_16;
	assign arsize  = ddr_tester_pkg::AXI_SIZE_8B;
	assign arburst = ddr_tester_pkg::AXI_BURST_INCR;
	assign hsize   = ddr_tester_pkg::HSIZE_WORD;
	assign hburst  = ddr_tester_pkg::HBURST_SINGLE;

	////////////////////////////////////////////////////////////////////////////////
	// buffer of 512 words of 64 bits
	logic [63:0] buf_ram [ddr_tester_pkg::RAM_DEPTH];

	ddr_tester_pkg::ctrl_state_t st_reg, st_next;
	ddr_tester_pkg::ahb_state_t  ahb_reg, ahb_next;
	logic [7:0]  cmd_prev_reg, cmd_prev_next;
	logic        op_rd_reg, op_rd_next;
	logic [5:0]  nbursts_reg, nbursts_next;
	logic [2:0]  rep_reg, rep_next;
	logic [31:0] wcnt_reg, wcnt_next, rcnt_reg, rcnt_next;
	logic [31:0] result_reg, result_next;
	logic [31:0] sram_addr_reg, sram_addr_next;
	logic        busy_next, resp_err_next;
	logic [31:0] awaddr_next, araddr_next;
	logic        awvalid_next, arvalid_next, wvalid_next, wlast_next;
	logic [63:0] wdata_next;
	logic [5:0]  aw_sent_reg, aw_sent_next, ar_sent_reg, ar_sent_next;
	logic [5:0]  w_burst_reg, w_burst_next, r_burst_reg, r_burst_next;
	logic [3:0]  w_beat_reg, w_beat_next, r_beat_reg, r_beat_next;
	logic [31:0] haddr_next, hwdata_next;
	logic [1:0]  htrans_next;
	logic        hwrite_next;
	logic        aw_fire, w_fire, ar_fire, r_fire, wr_trig, rd_trig, start;
	logic [2:0]  wsize_code, rsize_code;
	logic [5:0]  wsize_bursts, rsize_bursts;

	assign aw_fire = awvalid & awready;
	assign w_fire  = wvalid & wready;
	assign ar_fire = arvalid & arready;
	assign r_fire  = rvalid & rready;

	// rising edges trigger; size fields read at the trigger
	assign wr_trig = gpio_cmd[ddr_tester_pkg::CMD_WR_BIT]
		& ~cmd_prev_reg[ddr_tester_pkg::CMD_WR_BIT];
	assign rd_trig = gpio_cmd[ddr_tester_pkg::CMD_RD_BIT]
		& ~cmd_prev_reg[ddr_tester_pkg::CMD_RD_BIT];
	assign wsize_code = gpio_cmd[ddr_tester_pkg::CMD_WSIZE_LSB +: 3];
	assign rsize_code = gpio_cmd[ddr_tester_pkg::CMD_RSIZE_LSB +: 3];

	// burst count is 2**code, capped so the buffer is never overrun
	assign wsize_bursts = 6'h01 << ((wsize_code > ddr_tester_pkg::SIZE_CODE_MAX)
		? ddr_tester_pkg::SIZE_CODE_MAX : wsize_code);
	assign rsize_bursts = 6'h01 << ((rsize_code > ddr_tester_pkg::SIZE_CODE_MAX)
		? ddr_tester_pkg::SIZE_CODE_MAX : rsize_code);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next        = st_reg;
		cmd_prev_next  = gpio_cmd;
		op_rd_next     = op_rd_reg;
		nbursts_next   = nbursts_reg;
		rep_next       = rep_reg;
		wcnt_next      = wcnt_reg;
		rcnt_next      = rcnt_reg;
		result_next    = result_reg;
		sram_addr_next = sram_addr_reg;
		busy_next      = busy;
		resp_err_next  = resp_err;
		awaddr_next    = awaddr;
		araddr_next    = araddr;
		awvalid_next   = awvalid;
		arvalid_next   = arvalid;
		wvalid_next    = wvalid;
		wlast_next     = wlast;
		wdata_next     = wdata;
		aw_sent_next   = aw_sent_reg;
		ar_sent_next   = ar_sent_reg;
		w_burst_next   = w_burst_reg;
		w_beat_next    = w_beat_reg;
		r_burst_next   = r_burst_reg;
		r_beat_next    = r_beat_reg;
		start          = 1'b0;

		// Responses are watched, never waited on
		if (bvalid && bresp != ddr_tester_pkg::AXI_RESP_OKAY)
			resp_err_next = 1'b1;
		if (r_fire && rresp != ddr_tester_pkg::AXI_RESP_OKAY)
			resp_err_next = 1'b1;

		case (st_reg)
			ddr_tester_pkg::ST_IDLE: begin
				// triggers ignored until the controller is set up
				if (ddr_ready && (wr_trig || rd_trig)) begin
					op_rd_next     = ~wr_trig;
					nbursts_next   = wr_trig ? wsize_bursts : rsize_bursts;
					rep_next       = 3'h0;
					// results land from the SRAM base on
					sram_addr_next = ddr_tester_pkg::SRAM_BASE;
					busy_next      = 1'b1;
					start          = 1'b1;
				end
			end
			ddr_tester_pkg::ST_WRITE: begin
				// count every cycle from first AWVALID on
				wcnt_next = wcnt_reg + 32'h0000_0001;
				// AW runs ahead of data and of responses
				if (aw_fire) begin
					aw_sent_next = aw_sent_reg + 6'h01;
					awaddr_next  = awaddr + ddr_tester_pkg::BURST_BYTES;
					awvalid_next = (aw_sent_next != nbursts_reg);
				end
				if (w_fire)
					wvalid_next = 1'b0;
				// present next buffer word once its address is out
				if ((!wvalid || w_fire) && w_burst_reg != nbursts_reg
						&& w_burst_reg != aw_sent_reg) begin
					wvalid_next = 1'b1;
					wdata_next  = buf_ram[{w_burst_reg[4:0], w_beat_reg}];
					wlast_next  = (w_beat_reg == ddr_tester_pkg::BEAT_LAST);
					w_beat_next = w_beat_reg + 4'h1;
					if (w_beat_reg == ddr_tester_pkg::BEAT_LAST)
						w_burst_next = w_burst_reg + 6'h01;
				end
				// stop on WLAST of the final burst
				if (w_fire && wlast && w_burst_reg == nbursts_reg) begin
					result_next = wcnt_next;
					st_next     = ddr_tester_pkg::ST_REPORT;
				end
			end
			ddr_tester_pkg::ST_READ: begin
				// count every cycle from first ARVALID on
				rcnt_next = rcnt_reg + 32'h0000_0001;
				if (r_fire) begin
					r_beat_next = r_beat_reg + 4'h1;
					if (rlast)
						r_burst_next = r_burst_reg + 6'h01;
				end
				if (ar_fire) begin
					ar_sent_next = ar_sent_reg + 6'h01;
					araddr_next  = araddr + ddr_tester_pkg::BURST_BYTES;
				end
				// keep addresses flowing, at most five ahead
				if (!arvalid || ar_fire)
					arvalid_next = (ar_sent_next != nbursts_reg)
						&& (6'(ar_sent_next - r_burst_next) < ddr_tester_pkg::MAX_RD_QUEUE);
				// stop on RLAST of the final burst
				if (r_fire && rlast && r_burst_next == nbursts_reg) begin
					result_next = rcnt_next;
					st_next     = ddr_tester_pkg::ST_REPORT;
				end
			end
			ddr_tester_pkg::ST_REPORT: begin
				// AHB side takes count and address here
				if (ahb_reg == ddr_tester_pkg::AHB_IDLE) begin
					sram_addr_next = sram_addr_reg + ddr_tester_pkg::SRAM_STEP;
					st_next        = ddr_tester_pkg::ST_WAIT;
				end
			end
			ddr_tester_pkg::ST_WAIT: begin
				// Waiting keeps one result in flight, no queue needed
				if (ahb_reg == ddr_tester_pkg::AHB_IDLE) begin
					if (rep_reg == ddr_tester_pkg::REPEAT_LAST) begin
						busy_next = 1'b0;
						st_next   = ddr_tester_pkg::ST_IDLE;
					end else begin
						rep_next = rep_reg + 3'h1;
						start    = 1'b1;
					end
				end
			end
			default: begin
				st_next = ddr_tester_pkg::ST_IDLE;
			end
		endcase

		if (start) begin
			aw_sent_next = 6'h00;
			ar_sent_next = 6'h00;
			w_burst_next = 6'h00;
			w_beat_next  = 4'h0;
			r_burst_next = 6'h00;
			r_beat_next  = 4'h0;
			wcnt_next    = 32'h0000_0000;
			rcnt_next    = 32'h0000_0000;
			awaddr_next  = ddr_tester_pkg::WR_BASE;
			araddr_next  = ddr_tester_pkg::RD_BASE;
			awvalid_next = ~op_rd_next;
			arvalid_next = op_rd_next;
			st_next      = op_rd_next ? ddr_tester_pkg::ST_READ : ddr_tester_pkg::ST_WRITE;
		end
	end

	// single clock for engines, decoder and AHB side
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg        <= ddr_tester_pkg::ST_IDLE;
			cmd_prev_reg  <= 8'hFF;
			op_rd_reg     <= 1'b0;
			nbursts_reg   <= 6'h00;
			rep_reg       <= 3'h0;
			wcnt_reg      <= 32'h0000_0000;
			rcnt_reg      <= 32'h0000_0000;
			result_reg    <= 32'h0000_0000;
			sram_addr_reg <= ddr_tester_pkg::SRAM_BASE;
			busy          <= 1'b0;
			resp_err      <= 1'b0;
			awaddr        <= ddr_tester_pkg::WR_BASE;
			araddr        <= ddr_tester_pkg::RD_BASE;
			awvalid       <= 1'b0;
			arvalid       <= 1'b0;
			wvalid        <= 1'b0;
			wlast         <= 1'b0;
			wdata         <= 64'h0000_0000_0000_0000;
			aw_sent_reg   <= 6'h00;
			ar_sent_reg   <= 6'h00;
			w_burst_reg   <= 6'h00;
			w_beat_reg    <= 4'h0;
			r_burst_reg   <= 6'h00;
			r_beat_reg    <= 4'h0;
			bready        <= 1'b0;
			rready        <= 1'b0;
		end else if (clk_en) begin
			st_reg        <= st_next;
			cmd_prev_reg  <= cmd_prev_next;
			op_rd_reg     <= op_rd_next;
			nbursts_reg   <= nbursts_next;
			rep_reg       <= rep_next;
			wcnt_reg      <= wcnt_next;
			rcnt_reg      <= rcnt_next;
			result_reg    <= result_next;
			sram_addr_reg <= sram_addr_next;
			busy          <= busy_next;
			resp_err      <= resp_err_next;
			awaddr        <= awaddr_next;
			araddr        <= araddr_next;
			awvalid       <= awvalid_next;
			arvalid       <= arvalid_next;
			wvalid        <= wvalid_next;
			wlast         <= wlast_next;
			wdata         <= wdata_next;
			aw_sent_reg   <= aw_sent_next;
			ar_sent_reg   <= ar_sent_next;
			w_burst_reg   <= w_burst_next;
			w_beat_reg    <= w_beat_next;
			r_burst_reg   <= r_burst_next;
			r_beat_reg    <= r_beat_next;
			bready        <= 1'b1;
			rready        <= 1'b1;
		end
	end

	// returned beats written into the buffer in order
	always_ff @(posedge mclk) begin
		if (clk_en && r_fire && st_reg == ddr_tester_pkg::ST_READ)
			buf_ram[{r_burst_reg[4:0], r_beat_reg}] <= rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		ahb_next    = ahb_reg;
		haddr_next  = haddr;
		htrans_next = htrans;
		hwrite_next = hwrite;
		hwdata_next = hwdata;
		case (ahb_reg)
			ddr_tester_pkg::AHB_IDLE: begin
				// single word write of the count
				if (st_reg == ddr_tester_pkg::ST_REPORT) begin
					haddr_next  = sram_addr_reg;
					htrans_next = ddr_tester_pkg::HTRANS_NONSEQ;
					hwrite_next = 1'b1;
					hwdata_next = result_reg;
					ahb_next    = ddr_tester_pkg::AHB_ADDR;
				end
			end
			ddr_tester_pkg::AHB_ADDR: begin
				if (hready) begin
					htrans_next = ddr_tester_pkg::HTRANS_IDLE;
					hwrite_next = 1'b0;
					ahb_next    = ddr_tester_pkg::AHB_DATA;
				end
			end
			ddr_tester_pkg::AHB_DATA: begin
				if (hready)
					ahb_next = ddr_tester_pkg::AHB_IDLE;
			end
			default: begin
				ahb_next = ddr_tester_pkg::AHB_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ahb_reg <= ddr_tester_pkg::AHB_IDLE;
			haddr   <= 32'h0000_0000;
			htrans  <= ddr_tester_pkg::HTRANS_IDLE;
			hwrite  <= 1'b0;
			hwdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			ahb_reg <= ahb_next;
			haddr   <= haddr_next;
			htrans  <= htrans_next;
			hwrite  <= hwrite_next;
			hwdata  <= hwdata_next;
		end
	end

endmodule

// ### ddr_tester_chk.sv
`timescale 1ns/1ps
module ddr_tester_chk (
	input wire logic        mclk,      // Clock
	input wire logic        nrst,      // Reset
	input wire logic        ddr_ready, // Init done
	input wire logic        busy,      // Busy
	input wire logic [31:0] awaddr,    // AW addr
	input wire logic        awvalid,   // AW valid
	input wire logic        awready,   // AW ready
	input wire logic [63:0] wdata,     // W data
	input wire logic        wlast,     // W last
	input wire logic        wvalid,    // W valid
	input wire logic        wready,    // W ready
	input wire logic        bready,    // B ready
	input wire logic [31:0] araddr,    // AR addr
	input wire logic        arvalid,   // AR valid
	input wire logic        arready,   // AR ready
	input wire logic        rlast,     // R last
	input wire logic        rvalid,    // R valid
	input wire logic        rready,    // R ready
	input wire logic [1:0]  htrans,    // AHB trans
	input wire logic [31:0] haddr,     // AHB addr
	input wire logic        hwrite,    // AHB write
	input wire logic        hready     // AHB ready
);
	logic [3:0]  out_reg;
	logic [3:0]  beat_reg;
	logic [31:0] last_h_reg;

	// Outstanding read bursts, beat position, last SRAM target
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			out_reg    <= 4'h0;
			beat_reg   <= 4'h0;
			last_h_reg <= 32'h0;
		end else begin
			out_reg <= out_reg + 4'(arvalid && arready) - 4'(rvalid && rready && rlast);
			if (wvalid && wready)
				beat_reg <= beat_reg + 4'h1;
			if (htrans == ddr_tester_pkg::HTRANS_NONSEQ && hready)
				last_h_reg <= haddr;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence aw_hs; awvalid && awready; endsequence
	sequence ar_hs; arvalid && arready; endsequence
	sequence ahb_go; htrans == ddr_tester_pkg::HTRANS_NONSEQ && hready; endsequence

	aw_step_a: assert property (
		aw_hs |=> !awvalid || awaddr == $past(awaddr) + ddr_tester_pkg::BURST_BYTES)
		else $error("write address step wrong");
	ar_step_a: assert property (
		ar_hs |=> !arvalid || araddr == $past(araddr) + ddr_tester_pkg::BURST_BYTES)
		else $error("read address step wrong");
	aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
		else $error("write address dropped");
	w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable(wdata))
		else $error("write beat dropped");
	w_last_a: assert property (wvalid |-> wlast == (beat_reg == 4'hF))
		else $error("last beat misplaced");
	rd_queue_a: assert property (out_reg <= 4'h5)
		else $error("read queue too deep");
	no_early_a: assert property (!busy && !ddr_ready |=> !awvalid && !arvalid)
		else $error("access before init");
	resp_rdy_a: assert property (busy |-> bready && rready)
		else $error("response channel not ready");
	ahb_hold_a: assert property (
		htrans == ddr_tester_pkg::HTRANS_NONSEQ && !hready |=>
		htrans == ddr_tester_pkg::HTRANS_NONSEQ && $stable(haddr))
		else $error("ahb address dropped");
	ahb_step_a: assert property (ahb_go |-> hwrite && (haddr == ddr_tester_pkg::SRAM_BASE ||
		haddr == last_h_reg + ddr_tester_pkg::SRAM_STEP))
		else $error("sram address step wrong");
endmodule

bind ddr_axi_throughput_tester ddr_tester_chk chk (
	.mclk(mclk), .nrst(nrst), .ddr_ready(ddr_ready), .busy(busy), .awaddr(awaddr),
	.awvalid(awvalid), .awready(awready), .wdata(wdata), .wlast(wlast), .wvalid(wvalid),
	.wready(wready), .bready(bready), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rlast(rlast), .rvalid(rvalid), .rready(rready),
	.htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hready(hready)
);

// ### ddr_slave_model.sv
`timescale 1ns/1ps
module ddr_slave_model (
	input  wire logic        mclk,    // Clock
	input  wire logic        nrst,    // Reset
	input  wire logic        stall,   // Slow down
	input  wire logic        awvalid, // AW valid
	output logic             awready, // AW ready
	input  wire logic        wvalid,  // W valid
	input  wire logic        wlast,   // W last
	output logic             wready,  // W ready
	output logic             bvalid,  // B valid
	output logic [1:0]       bresp,   // B resp
	input  wire logic        bready,  // B ready
	input  wire logic [31:0] araddr,  // AR addr
	input  wire logic        arvalid, // AR valid
	output logic             arready, // AR ready
	output logic [63:0]      rdata,   // R data
	output logic [1:0]       rresp,   // R resp
	output logic             rlast,   // R last
	output logic             rvalid,  // R valid
	input  wire logic        rready   // R ready
);
	logic [31:0] q[$];
	logic [31:0] a;
	int          qn;
	int          bpend;
	int          beat;

	// Queue capped above the design limit so its own limit is what bites
	assign awready = !stall;
	assign wready  = !stall;
	assign arready = !stall && qn < 6;
	assign bresp   = ddr_tester_pkg::AXI_RESP_OKAY;
	assign rresp   = ddr_tester_pkg::AXI_RESP_OKAY;

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			rlast  <= 1'b0;
			rdata  <= 64'h0;
			qn     <= 0;
			bpend = 0;
			beat  = 0;
			q.delete();
		end else begin
			if (wvalid && wready && wlast)
				bpend++;
			if (bvalid && bready)
				bpend--;
			bvalid <= bpend > 0;
			if (arvalid && arready)
				q.push_back(araddr);
			if (rvalid && rready) begin
				beat++;
				if (beat == 16) begin
					beat = 0;
					void'(q.pop_front());
				end
			end
			// Idle data is scrambled; RLAST keeps its last value
			if (!rvalid || rready) begin
				if (q.size() > 0 && !stall) begin
					a = q[0] + beat * 8;
					rvalid <= 1'b1;
					rdata  <= {a, ~a};
					rlast  <= beat == 15;
				end else begin
					rvalid <= 1'b0;
					rdata  <= ~rdata;
				end
			end
			qn <= q.size();
		end
	end
endmodule

// ### ddr_axi_throughput_tester_bench.sv
`timescale 1ns/1ps
module ddr_axi_throughput_tester_bench;
	logic        mclk = 0, nrst = 0, clk_en = 1, ddr_ready = 0, stall = 0, hready = 1;
	logic [7:0]  gpio_cmd = 8'h00;
	logic        busy, resp_err, awvalid, awready, wlast, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rlast, rvalid, rready, hwrite;
	logic [1:0]  awburst, arburst, bresp, rresp, htrans;
	logic [2:0]  awsize, arsize, hsize, hburst;
	logic [3:0]  awlen, arlen;
	logic [7:0]  wstrb;
	logic [31:0] awaddr, araddr, haddr, hwdata, a;
	logic [63:0] wdata, rdata;
	logic [31:0] aq[$], cq[$];
	int          errors = 0, n_checks = 0, seed = 32'h4e0a;
	int          nb, cyc, nbr, nad, nw;
	bit          on = 0, rd = 0, dph = 0;

	always #25 mclk = ~mclk;

	ddr_axi_throughput_tester dut (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .gpio_cmd(gpio_cmd),
		.ddr_ready(ddr_ready), .busy(busy), .resp_err(resp_err), .awaddr(awaddr),
		.awlen(awlen), .awsize(awsize), .awburst(awburst), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arlen(arlen), .arsize(arsize), .arburst(arburst),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rlast(rlast),
		.rvalid(rvalid), .rready(rready), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hwdata(hwdata), .hready(hready)
	);
	ddr_slave_model ddr (
		.mclk(mclk), .nrst(nrst), .stall(stall), .awvalid(awvalid), .awready(awready),
		.wvalid(wvalid), .wlast(wlast), .wready(wready), .bvalid(bvalid), .bresp(bresp),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rlast(rlast), .rvalid(rvalid), .rready(rready)
	);
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task run(input bit r, input logic [2:0] sz);
		int i;
		rd = r;
		nb = 1 << ((sz > 3'h5) ? 5 : sz);
		for (i = 0; i < 8; i++)
			aq.push_back(ddr_tester_pkg::SRAM_BASE + i * 4);
		@(negedge mclk);
		gpio_cmd = r ? {sz, 3'h0, 2'h2} : {3'h0, sz, 2'h1};
		@(negedge mclk);
		chk("busy", busy, 1);
		// Trigger of the other kind mid-run must be ignored
		for (i = 0; i < 40000 && busy !== 1'b0; i++) begin
			@(negedge mclk);
			gpio_cmd[1:0] = (i == 50) ? {!r, r} : 2'h0;
		end
		repeat (4) @(negedge mclk);
		chk("results left", aq.size(), 0);
		chk("counts left", cq.size(), 0);
		$display("test done dir %0d size %0d", r, sz);
	endtask

	always @(negedge mclk) begin
		stall  <= ($random(seed) & 3) == 0;
		hready <= ($random(seed) & 3) != 0;
	end

	// Reference of the cycle counter and the address and data streams
	always @(posedge mclk) begin
		if (dph && hready) begin
			chk("hwdata", hwdata, cq.pop_front());
			dph = 0;
		end else if (htrans == ddr_tester_pkg::HTRANS_NONSEQ && hready) begin
			chk("haddr", haddr, aq.pop_front());
			dph = 1;
		end
		if (!on && busy === 1'b1 && (rd ? arvalid : awvalid) === 1'b1) begin
			on = 1;
			cyc = 0;
			nbr = 0;
			nad = 0;
			nw = 0;
		end
		if (on) begin
			cyc++;
			if (!rd && awvalid && awready) begin
				chk("awaddr", awaddr, ddr_tester_pkg::WR_BASE + nad * 128);
				chk("awlen", {awlen, awsize, awburst}, {4'hF, 3'h3, 2'h1});
				nad++;
			end
			if (rd && arvalid && arready) begin
				chk("araddr", araddr, ddr_tester_pkg::RD_BASE + nad * 128);
				nad++;
			end
			if (!rd && wvalid && wready) begin
				a = ddr_tester_pkg::RD_BASE + nw * 8;
				chk("wdata", wdata, {a, ~a});
				chk("wlast", wlast, nw % 16 == 15);
				nw++;
				if (wlast)
					nbr++;
			end
			if (rd && rvalid && rready && rlast)
				nbr++;
			if (nbr == nb) begin
				chk("bursts", nad, nb);
				cq.push_back(cyc);
				on = 0;
			end
		end
	end

	initial begin
		repeat (90000) @(posedge mclk);
		errors++;
		$display("watchdog expired");
		end_sim;
	end

	initial begin
		repeat (2) @(negedge mclk);
		nrst = 1;
		repeat (4) @(negedge mclk);
		gpio_cmd = 8'h01;
		repeat (5) @(negedge mclk);
		chk("busy", busy, 0);
		gpio_cmd = 8'h00;
		repeat (2) @(negedge mclk);
		ddr_ready = 1;
		// Reads fill the buffer that the next writes send out
		run(1, 3'h1);
		run(0, 3'h1);
		run(1, 3'h4);
		run(0, 3'h4);
		run(1, 3'h7);
		run(0, 3'h0);
		chk("resp_err", resp_err, 0);
		end_sim;
	end
endmodule
